//--- hw/riaf_framer.sv
// Route information and aggregate address update frame builder
module riaf_framer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic api_en,
  input wire logic route_valid,
  output logic route_ready,
  input wire riaf_pkg::riaf_route_t route_req,
  input wire logic addr_upd_valid,
  output logic addr_upd_ready,
  input wire logic [63:0] addr_upd_new,
  output logic [31:0] dest_addr_high_reg,
  output logic [31:0] dest_addr_low_reg,
  output logic busy,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_byte
);
  riaf_pkg::riaf_state_t state_ff;
  riaf_pkg::riaf_state_t nxt_state;
  logic [riaf_pkg::FRAME_BITS-1:0] frame_ff;
  logic [riaf_pkg::FRAME_BITS-1:0] nxt_frame;
  logic [15:0] len_ff;
  logic [15:0] nxt_len;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [7:0] sum_ff;
  logic [7:0] nxt_sum;
  logic [63:0] dest_ff;
  logic [63:0] nxt_dest;
  logic [31:0] timer_ff;
  logic [31:0] nxt_timer;
  logic [3:0] tick_ff;
  logic [3:0] nxt_tick;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic route_ok;
  logic [7:0] route_ev;

  // Microsecond timer, free running and wrapping at 32 bits
  always_comb begin
    nxt_tick = tick_ff + 4'h1;
    nxt_timer = timer_ff;
    if (tick_ff == riaf_pkg::TICK_LAST) begin
      nxt_tick = 4'h0;
      nxt_timer = timer_ff + 32'h1;
    end
  end

  // Timer registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_ff <= 4'h0;
      timer_ff <= riaf_pkg::TIMER_RST;
    end else begin
      tick_ff <= nxt_tick;
      timer_ff <= nxt_timer;
    end
  end

  // Route report qualification and event code
  always_comb begin
    route_ok = route_req.unicast &&
               (route_req.is_trace ? route_req.trace_en : route_req.nack_en);
    route_ev = route_req.is_trace ? riaf_pkg::EV_TRACE : riaf_pkg::EV_NACK;
  end

  // Request handshakes: address updates win over route reports
  always_comb begin
    addr_upd_ready = (state_ff == riaf_pkg::ST_IDLE);
    route_ready = (state_ff == riaf_pkg::ST_IDLE) && !addr_upd_valid;
    busy = (state_ff != riaf_pkg::ST_IDLE);
  end

  // Framer next state, frame image, length, count and checksum
  always_comb begin
    nxt_state = state_ff;
    nxt_frame = frame_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_sum = sum_ff;
    nxt_dest = dest_ff;
    fifo_in_valid = 1'b0;
    fifo_in_data = 8'h00;
    case (state_ff)
      riaf_pkg::ST_IDLE: begin
        if (addr_upd_valid) begin
          nxt_dest = addr_upd_new;
          if (api_en) begin
            // Frame image: type, format, new then old address, MSB first
            nxt_frame = {riaf_pkg::FT_ADDR, riaf_pkg::FMT_ID,
                         addr_upd_new, dest_ff,
                         {riaf_pkg::ADDR_PAD_BITS{1'b0}}};
            nxt_len = riaf_pkg::ADDR_DATA_LEN;
            nxt_state = riaf_pkg::ST_DELIM;
          end
        end else if (route_valid && route_ok) begin
          // Frame image in offset order, every field MSB first
          nxt_frame = {riaf_pkg::FT_ROUTE, route_ev, riaf_pkg::ROUTE_INNER_LEN,
                       timer_ff,
                       route_req.ack_timeouts, riaf_pkg::ROUTE_RSVD,
                       route_req.dest_addr, route_req.src_addr,
                       route_req.resp_addr, route_req.recv_addr};
          nxt_len = riaf_pkg::ROUTE_DATA_LEN;
          nxt_state = riaf_pkg::ST_DELIM;
        end
      end
      riaf_pkg::ST_DELIM: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = riaf_pkg::START_DELIM;
        if (fifo_in_ready) begin
          nxt_state = riaf_pkg::ST_LEN_HI;
        end
      end
      riaf_pkg::ST_LEN_HI: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = len_ff[15:8];
        if (fifo_in_ready) begin
          nxt_state = riaf_pkg::ST_LEN_LO;
        end
      end
      riaf_pkg::ST_LEN_LO: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = len_ff[7:0];
        if (fifo_in_ready) begin
          nxt_cnt = len_ff[5:0];
          nxt_sum = 8'h00;
          nxt_state = riaf_pkg::ST_DATA;
        end
      end
      riaf_pkg::ST_DATA: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = frame_ff[riaf_pkg::FRAME_BITS-1 -: 8];
        if (fifo_in_ready) begin
          nxt_frame = {frame_ff[riaf_pkg::FRAME_BITS-9:0], 8'h00};
          nxt_sum = sum_ff + frame_ff[riaf_pkg::FRAME_BITS-1 -: 8];
          nxt_cnt = cnt_ff - 6'h01;
          if (cnt_ff == 6'h01) begin
            nxt_state = riaf_pkg::ST_CSUM;
          end
        end
      end
      riaf_pkg::ST_CSUM: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = riaf_pkg::CSUM_BASE - sum_ff;
        if (fifo_in_ready) begin
          nxt_state = riaf_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = riaf_pkg::ST_IDLE;
      end
    endcase
  end

  // Framer registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= riaf_pkg::ST_IDLE;
      frame_ff <= '0;
      len_ff <= 16'h0000;
      cnt_ff <= 6'h00;
      sum_ff <= 8'h00;
      dest_ff <= riaf_pkg::DEST_ADDR_RST;
    end else begin
      state_ff <= nxt_state;
      frame_ff <= nxt_frame;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      sum_ff <= nxt_sum;
      dest_ff <= nxt_dest;
    end
  end

  // Destination address register halves
  always_comb begin
    dest_addr_high_reg = dest_ff[63:32];
    dest_addr_low_reg = dest_ff[31:0];
  end

  // Output byte buffer, stalls the framer when the host holds off
  riaf_fifo #(
    .WIDTH(riaf_pkg::BYTE_W),
    .DEPTH(riaf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_byte)
  );
endmodule

//--- hw/riaf_pkg.sv
// Constants and types shared by the route information and address update framer
package riaf_pkg;
  // Clock and timestamp tick
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TIMER_TICK_NS = 1000;
  localparam int unsigned TICK_CYC = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);
  // Frame codes
  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] FT_ROUTE = 8'h8d;
  localparam logic [7:0] FT_ADDR = 8'h8e;
  localparam logic [7:0] EV_NACK = 8'h11;
  localparam logic [7:0] EV_TRACE = 8'h12;
  localparam logic [7:0] FMT_ID = 8'h00;
  localparam logic [15:0] ROUTE_RSVD = 16'h0000;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  // Lengths: route frame data spans offsets 3..44, inner length counts 6..44
  localparam logic [15:0] ROUTE_DATA_LEN = 16'h002a;
  localparam logic [7:0] ROUTE_INNER_LEN = 8'h27;
  localparam logic [15:0] ADDR_DATA_LEN = 16'h0012;
  // Reset values
  localparam logic [63:0] DEST_ADDR_RST = 64'h0000000000000000;
  localparam logic [31:0] TIMER_RST = 32'h00000000;
  // Buffer geometry
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FRAME_BITS = 336;
  localparam int unsigned ADDR_PAD_BITS = 192;

  // One route report request
  typedef struct packed {
    logic unicast;
    logic nack_en;
    logic trace_en;
    logic is_trace;
    logic [7:0] ack_timeouts;
    logic [63:0] dest_addr;
    logic [63:0] src_addr;
    logic [63:0] resp_addr;
    logic [63:0] recv_addr;
  } riaf_route_t;

  // Framer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DELIM = 6'b000010,
    ST_LEN_HI = 6'b000100,
    ST_LEN_LO = 6'b001000,
    ST_DATA = 6'b010000,
    ST_CSUM = 6'b100000
  } riaf_state_t;
endpackage

//--- hw/riaf_fifo.sv
// Byte FIFO with valid and ready on both sides
module riaf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [AW:0] nxt_wr;
  logic [AW:0] nxt_rd;
  logic push;
  logic pop;

  // Full and empty from pointers with a wrap bit
  always_comb begin
    in_ready = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
    out_valid = (wr_ff != rd_ff);
    out_data = mem_ff[rd_ff[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
  end

  // Pointers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // Storage, written only on push
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

//--- tb/riaf_assertions.sv
// Port checker for the framer
module riaf_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic api_en,
  input wire logic route_valid,
  input wire logic route_ready,
  input wire riaf_pkg::riaf_route_t route_req,
  input wire logic addr_upd_valid,
  input wire logic addr_upd_ready,
  input wire logic [63:0] addr_upd_new,
  input wire logic [31:0] dest_addr_high_reg,
  input wire logic [31:0] dest_addr_low_reg,
  input wire logic busy,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic tk_a;
  logic tk_r;
  logic ok_r;
  // Accepted requests and whether a route report qualifies
  assign tk_a = addr_upd_valid && addr_upd_ready;
  assign tk_r = route_valid && route_ready;
  assign ok_r = route_req.unicast && (route_req.is_trace ? route_req.trace_en : route_req.nack_en);
  sequence s_go;
    tk_r && ok_r;
  endsequence
  sequence s_delim;
    tx_valid && tx_byte == riaf_pkg::START_DELIM;
  endsequence
  a_regs_load: assert property (tk_a |=> {dest_addr_high_reg, dest_addr_low_reg} == $past(addr_upd_new)) else $error("regs not loaded");
  a_regs_keep: assert property (!tk_a |=> $stable({dest_addr_high_reg, dest_addr_low_reg})) else $error("regs moved");
  a_addr_frame: assert property (tk_a && api_en |=> busy) else $error("no update frame");
  a_addr_quiet: assert property (tk_a && !api_en |=> !busy) else $error("frame without api");
  a_route_drop: assert property (tk_r && !ok_r |=> !busy) else $error("report not dropped");
  a_route_go: assert property (s_go |=> busy) else $error("report lost");
  a_delim_first: assert property (!tx_valid ##0 s_go |=> busy ##1 s_delim) else $error("no delimiter");
  a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("byte dropped");
  a_busy_refuse: assert property (busy |-> !route_ready && !addr_upd_ready) else $error("ready while busy");
endmodule
bind riaf_framer riaf_assertions riaf_assertions_inst (.mclk, .rst_n, .api_en, .route_valid,
  .route_ready, .route_req, .addr_upd_valid, .addr_upd_ready, .addr_upd_new, .dest_addr_high_reg,
  .dest_addr_low_reg, .busy, .tx_valid, .tx_ready, .tx_byte);

//--- tb/riaf_host.sv
// Host model that takes bytes with random stalls
module riaf_host (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stalls one cycle in three, fully while hold is set so the buffer fills
  initial tx_ready = 0;
  always @(negedge mclk) tx_ready <= rst_n && !hold && ($urandom % 3 != 0);
  int idx = 0;
  logic [15:0] len = '0;
  // Closes each frame by its outer length alone, so items past the known fields are skipped
  always @(posedge mclk) begin
    if (!rst_n) begin
      idx = 0;
      frames = 0;
    end else if (tx_valid === 1'b1 && tx_ready) begin
      if (idx == 1) len[15:8] = tx_byte;
      if (idx == 2) len[7:0] = tx_byte;
      if (idx > 2 && idx == len + 3) begin
        frames = frames + 1;
        idx = 0;
      end else if (idx != 0 || tx_byte == riaf_pkg::START_DELIM) begin
        idx = idx + 1;
      end
    end
  end
endmodule

//--- tb/riaf_framer_test.sv
// Self-checking bench for the framer
module riaf_framer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, api_en = 0, route_valid = 0, addr_upd_valid = 0, hold = 1;
  riaf_pkg::riaf_route_t route_req = '0;
  logic [63:0] addr_upd_new = '0, old = '0;
  logic route_ready, addr_upd_ready, busy, tx_valid, tx_ready;
  logic [31:0] dest_addr_high_reg, dest_addr_low_reg;
  logic [7:0] tx_byte, sum;
  logic [9:0] e;
  logic [9:0] q[$];
  int error_cnt = 0, n_checks = 0;
  int n_frames = 0, frames;
  int unsigned cyc = 0;
  bit ts_due = 0;
  logic [31:0] ts;
  logic [31:0] ts_q[$];
  riaf_framer riaf_framer_inst (.mclk, .rst_n, .api_en, .route_valid, .route_ready, .route_req,
    .addr_upd_valid, .addr_upd_ready, .addr_upd_new, .dest_addr_high_reg, .dest_addr_low_reg,
    .busy, .tx_valid, .tx_ready, .tx_byte);
  riaf_host riaf_host_inst (.mclk, .rst_n, .hold, .tx_valid, .tx_byte, .tx_ready, .frames);
  initial forever #50 mclk = ~mclk;
  // Edges since reset release, the base of the expected timestamp
  always @(posedge mclk) cyc <= rst_n ? cyc + 1 : 0;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(string what, logic [63:0] x, logic [63:0] g);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, x, g);
    end
  endtask
  // Kind 0 exact, 1 timestamp, 2 checksum, 3 frame type
  task automatic put(logic [1:0] k, logic [7:0] b);
    q.push_back({k, b});
  endtask
  task automatic put_n(logic [63:0] v, int n);
    for (int i = n - 1; i >= 0; i--) put(2'd0, v[8*i +: 8]);
  endtask
  task automatic hs(bit a);
    if (a) addr_upd_valid = 1;
    else route_valid = 1;
    do @(posedge mclk); while ((a ? addr_upd_ready : route_ready) !== 1'b1);
    if (!a && ts_due) begin
      ts_q.push_back(32'(cyc / riaf_pkg::TICK_CYC));
      ts_due = 0;
    end
    @(negedge mclk);
    if (a) addr_upd_valid = 0;
    else route_valid = 0;
    @(negedge mclk);
  endtask
  task automatic pexp();
    if (route_req.unicast && (route_req.is_trace ? route_req.trace_en : route_req.nack_en)) begin
      ts_due = 1;
      n_frames++;
      put_n({40'h0, riaf_pkg::START_DELIM, riaf_pkg::ROUTE_DATA_LEN}, 3);
      put(2'd3, riaf_pkg::FT_ROUTE);
      put(2'd0, route_req.is_trace ? riaf_pkg::EV_TRACE : riaf_pkg::EV_NACK);
      put(2'd0, riaf_pkg::ROUTE_INNER_LEN);
      for (int i = 0; i < 4; i++) put(2'd1, 8'(i));
      put_n({route_req.ack_timeouts, 16'h0000}, 3);
      for (int i = 0; i < 4; i++) put_n(route_req[255-64*i -: 64], 8);
      put(2'd2, 8'h00);
    end
  endtask
  task automatic upd(logic [63:0] v);
    if (api_en) begin
      n_frames++;
      put_n({40'h0, riaf_pkg::START_DELIM, riaf_pkg::ADDR_DATA_LEN}, 3);
      put(2'd3, riaf_pkg::FT_ADDR);
      put(2'd0, riaf_pkg::FMT_ID);
      put_n(v, 8);
      put_n(old, 8);
      put(2'd2, 8'h00);
    end
    addr_upd_new = v;
    old = v;
    hs(1);
    cmp("dest regs", v, {dest_addr_high_reg, dest_addr_low_reg});
  endtask
  // Each byte taken by the host is matched against the oldest note
  always @(posedge mclk) if ((rst_n & tx_valid & tx_ready) === 1'b1) begin
    if (q.size() == 0) cmp("extra byte", 0, 1);
    else begin
      e = q.pop_front();
      if (e[9:8] == 2'd3) sum = 0;
      if (e[9:8] == 2'd1) begin
        ts = {ts[23:0], tx_byte};
        if (e[1:0] == 2'd3) cmp("timestamp", ts_q.pop_front(), ts);
      end
      if (e[9:8] == 2'd2) cmp("checksum", 8'hff, 8'(sum + tx_byte));
      else if (e[9:8] != 2'd1) cmp("tx byte", e[7:0], tx_byte);
      sum = sum + tx_byte;
    end
  end
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
  initial begin
    void'($urandom(21908));
    repeat (6) @(negedge mclk);
    rst_n = 1;
    api_en = 1;
    @(negedge mclk);
    cmp("idle after reset", 4'hc, {route_ready, addr_upd_ready, busy, tx_valid});
    cmp("dest after reset", riaf_pkg::DEST_ADDR_RST, {dest_addr_high_reg, dest_addr_low_reg});
    fork begin
      repeat (300) @(negedge mclk);
      hold = 0;
    end join_none
    // Every mix of unicast, enables and report source
    for (int m = 0; m < 16; m++) begin
      route_req = {4'(m), 8'($urandom), {8{$urandom}}};
      pexp();
      hs(0);
    end
    $display("route tests done");
    upd({$urandom, $urandom});
    upd(old);
    api_en = 0;
    upd({$urandom, $urandom});
    api_en = 1;
    route_valid = 1;
    upd({$urandom, $urandom});
    pexp();
    hs(0);
    $display("address tests done");
    while (q.size() != 0) @(negedge mclk);
    repeat (60) @(negedge mclk);
    cmp("busy", 0, busy);
    cmp("frames", n_frames, frames);
    conclude();
  end
endmodule
